// >>> sbf_assertions.sv
// checker for the sensor-break fault handler
`timescale 1ns/1ps
`default_nettype none
module sbf_checker
   import sbf_pkg::*;
(
   // clock and reset
   input wire logic         mclk_i,
   input wire logic         reset_i,
   // inputs
   input wire sbf_resp_e    break_response_select_i,
   input wire sbf_outmode_e output_mode_i,
   input wire logic         config_mode_i,
   input wire logic [1:0]   access_level_i,
   input wire logic         shift_wr_i,
   input wire sbf_value_t   shift_data_i,
   input wire logic         ack_key_i,
   // results
   input wire sbf_value_t   control_out_o,
   input wire logic         break_active_o,
   input wire logic         fault_lamp_o,
   input wire logic         alarm_relay_o,
   input wire sbf_limits_s  output_limits_o,
   input wire sbf_value_t   fallback_value_o,
   input wire sbf_value_t   process_value_shift_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sbf_resp_e    rp;
   sbf_outmode_e mp;
   sbf_value_t   up;
   sbf_value_t   lo;
   logic         shok;
   assign up = output_limits_o.upper;
   assign lo = output_limits_o.lower;
   assign shok = access_level_i == SBF_LEVEL_THREE || config_mode_i;
   // previous selections
   always_ff @(posedge mclk_i) begin
      rp <= break_response_select_i;
      mp <= output_mode_i;
   end
   a_off_quiet: assert property (rp == SBF_RESP_OFF |-> !alarm_relay_o)
      else $error("alarm in off mode");
   a_off_upper: assert property (break_active_o && rp == SBF_RESP_OFF
      && $stable(output_limits_o) |-> control_out_o == up)
      else $error("off mode output not upper");
   a_on_safe: assert property (break_active_o && rp != SBF_RESP_OFF
      && $stable(output_limits_o) && $stable(fallback_value_o)
      |-> control_out_o == fallback_value_o)
      else $error("break output not fallback");
   a_safe_inside: assert property (lo <= fallback_value_o
      && fallback_value_o <= up) else $error("fallback outside limits");
   a_limit_span: assert property (up <= SBF_FULL_SCALE && lo <= up
      && lo >= SBF_NEG_FULL_SCALE && (mp != SBF_OUT_COOL_ONLY || up <= 0)
      && (mp != SBF_OUT_HEAT_ONLY || lo >= 0)) else $error("limit range");
   a_on_follow: assert property (rp == SBF_RESP_ON
      |-> alarm_relay_o == break_active_o) else $error("on alarm");
   a_latch_ack: assert property ($fell(alarm_relay_o)
      && rp == SBF_RESP_LATCH |-> $past(ack_key_i, 3)
      && !$past(ack_key_i, 4)) else $error("latched alarm cleared");
   a_alarm_start: assert property ($rose(alarm_relay_o)
      |-> break_active_o && fault_lamp_o) else $error("alarm start");
   a_lamp_gate: assert property (fault_lamp_o |-> alarm_relay_o)
      else $error("lamp without alarm");
   a_lamp_flash: assert property (fault_lamp_o[*8] |=> !fault_lamp_o)
      else $error("lamp not flashing");
   a_shift_gate: assert property (shift_wr_i && !shok
      |=> $stable(process_value_shift_o)) else $error("shift taken");
   a_shift_take: assert property (shift_wr_i && shok
      |=> process_value_shift_o == $past(shift_data_i))
      else $error("shift lost");
   c_alarm: cover property ($rose(alarm_relay_o));
   c_latch: cover property ($fell(alarm_relay_o) && rp == SBF_RESP_LATCH);
   c_off: cover property (break_active_o && rp == SBF_RESP_OFF);
endmodule
bind sbf_break_handler sbf_checker u_chk (.mclk_i, .reset_i,
   .break_response_select_i, .output_mode_i, .config_mode_i,
   .access_level_i, .shift_wr_i, .shift_data_i, .ack_key_i, .control_out_o,
   .break_active_o, .fault_lamp_o, .alarm_relay_o, .output_limits_o,
   .fallback_value_o, .process_value_shift_o);
`default_nettype wire

// >>> sbf_break_handler.sv
// sensor-break response, alarm, serial timeout and process value shift
`timescale 1ns/1ps
`default_nettype none
module sbf_break_handler
   import sbf_pkg::*;
#(
   parameter longint HOST_TIMEOUT_CYC = SBF_HOST_TIMEOUT_CYC,
   parameter longint FLASH_HALF_CYC   = SBF_FLASH_HALF_CYC
) (
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          reset_i,
   // configuration
   input  wire sbf_resp_e     break_response_select_i,
   input  wire sbf_outmode_e  output_mode_i,
   input  wire logic          break_detect_en_i,
   input  wire logic          serial_source_i,
   input  wire logic          linear_mode_i,
   input  wire logic          config_mode_i,
   input  wire logic [1:0]    access_level_i,
   // setting writes
   input  wire logic          limits_wr_i,
   input  wire sbf_limits_s   limits_data_i,
   input  wire logic          fallback_wr_i,
   input  wire sbf_value_t    fallback_data_i,
   input  wire logic          shift_wr_i,
   input  wire sbf_value_t    shift_data_i,
   input  wire logic          linear_wr_i,
   input  wire sbf_limits_s   linear_data_i,
   input  wire sbf_twopoint_s twopoint_i,
   // process input
   input  wire logic          sensor_open_i,
   input  wire sbf_value_t    measured_pv_i,
   input  wire sbf_value_t    linear_mv_i,
   input  wire sbf_value_t    control_demand_i,
   input  wire sbf_host_wr_s  host_wr_i,
   // operator keypad
   input  wire logic          ack_key_i,
   // results
   output sbf_value_t         control_out_o,
   output sbf_value_t         process_value_o,
   output logic               break_active_o,
   output logic               fault_lamp_o,
   output logic               alarm_relay_o,
   output sbf_limits_s        output_limits_o,
   output sbf_value_t         fallback_value_o,
   output sbf_value_t         process_value_shift_o,
   output sbf_limits_s        linear_limits_o
);

   localparam logic [31:0] TIMEOUT_CNT = 32'(HOST_TIMEOUT_CYC);
   localparam logic [31:0] FLASH_CNT   = 32'(FLASH_HALF_CYC);

   function automatic sbf_value_t clamp(input sbf_value_t v,
                                        input sbf_value_t lo,
                                        input sbf_value_t hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      else
         return v;
   endfunction

   // synchronised pins
   logic open_sync;
   logic ack_sync;
   logic ack_prev_reg;
   logic ack_pulse;

   sbf_sync2 u_open_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (sensor_open_i),
      .sync_o  (open_sync)
   );

   sbf_sync2 u_ack_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (ack_key_i),
      .sync_o  (ack_sync)
   );

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         ack_prev_reg <= 1'b0;
      else
         ack_prev_reg <= ack_sync;
   end

   assign ack_pulse = ack_sync & ~ack_prev_reg;

   // limits bounded by output arrangement
   sbf_value_t mode_min;
   sbf_value_t mode_max;
   sbf_limits_s limits_reg;
   sbf_limits_s limits_next;

   always_comb begin
      case (output_mode_i)
         SBF_OUT_HEAT_ONLY: begin
            mode_min = SBF_ZERO;
            mode_max = SBF_FULL_SCALE;
         end
         SBF_OUT_COOL_ONLY: begin
            mode_min = SBF_NEG_FULL_SCALE;
            mode_max = SBF_ZERO;
         end
         default: begin
            mode_min = SBF_NEG_FULL_SCALE;
            mode_max = SBF_FULL_SCALE;
         end
      endcase
      limits_next = limits_wr_i ? limits_data_i : limits_reg;
      limits_next.upper = clamp(limits_next.upper, mode_min, mode_max);
      limits_next.lower = clamp(limits_next.lower, mode_min,
                                limits_next.upper);
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         limits_reg.upper <= SBF_FULL_SCALE;
         limits_reg.lower <= SBF_ZERO;
      end else begin
         limits_reg <= limits_next;
      end
   end

   // stored fallback kept inside the limits
   sbf_value_t fallback_reg;
   sbf_value_t fallback_next;

   always_comb begin
      fallback_next = fallback_wr_i ? fallback_data_i : fallback_reg;
      fallback_next = clamp(fallback_next, limits_next.lower,
                            limits_next.upper);
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         fallback_reg <= SBF_ZERO;
      else
         fallback_reg <= fallback_next;
   end

   // user shift, level three or configuration only
   sbf_value_t shift_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         shift_reg <= SBF_ZERO;
      else if (shift_wr_i &&
               (config_mode_i || access_level_i == SBF_LEVEL_THREE))
         shift_reg <= shift_data_i;
   end

   // linear input floor and ceiling
   sbf_limits_s linear_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         linear_reg.upper <= SBF_LIN_MAX;
         linear_reg.lower <= SBF_LIN_MIN;
      end else if (linear_wr_i && config_mode_i) begin
         linear_reg.upper <= clamp(linear_data_i.upper,
                                   SBF_LIN_MIN, SBF_LIN_MAX);
         linear_reg.lower <= clamp(linear_data_i.lower,
                                   SBF_LIN_MIN, SBF_LIN_MAX);
      end
   end

   // serial process value and its watchdog
   logic        host_hit;
   sbf_value_t  serial_pv_reg;
   logic [31:0] host_age_reg;
   logic        host_stale;

   assign host_hit = host_wr_i.wr && host_wr_i.addr == SBF_PV_HOLD_ADDR;

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         serial_pv_reg <= SBF_ZERO;
      else if (host_hit)
         serial_pv_reg <= host_wr_i.data;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         host_age_reg <= SBF_CNT_ZERO;
      else if (host_hit)
         host_age_reg <= SBF_CNT_ZERO;
      else if (host_age_reg < TIMEOUT_CNT)
         host_age_reg <= host_age_reg + SBF_CNT_ONE;
   end

   assign host_stale = host_age_reg >= TIMEOUT_CNT;

   // linear range check with five percent margin
   logic signed [31:0] lin_margin;
   logic               lin_out;

   always_comb begin
      lin_margin = (32'(linear_reg.upper) - 32'(linear_reg.lower))
                   / SBF_LIN_MARGIN_DIV;
      lin_out = (32'(linear_mv_i) < 32'(linear_reg.lower) - lin_margin) ||
                (32'(linear_mv_i) > 32'(linear_reg.upper) + lin_margin);
   end

   // break condition
   logic break_now;
   logic break_reg;

   always_comb begin
      if (serial_source_i)
         break_now = host_stale;
      else
         break_now = break_detect_en_i &&
                     (open_sync || (linear_mode_i && lin_out));
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         break_reg <= 1'b0;
      else
         break_reg <= break_now;
   end

   // two-point correction and shift
   logic signed [31:0] raw_pv;
   logic signed [31:0] tp_span;
   logic signed [47:0] tp_prod;
   logic signed [31:0] tp_shift;
   sbf_value_t         pv_reg;

   always_comb begin
      raw_pv  = serial_source_i ? 32'(serial_pv_reg) : 32'(measured_pv_i);
      tp_span = 32'(twopoint_i.high_point) - 32'(twopoint_i.low_point);
      tp_prod = (48'(twopoint_i.high_shift) - 48'(twopoint_i.low_shift)) *
                (48'(raw_pv) - 48'(twopoint_i.low_point));
      if (tp_span == 32'sh0)
         tp_shift = 32'(twopoint_i.low_shift);
      else
         tp_shift = 32'(twopoint_i.low_shift) +
                    32'(tp_prod / 48'(tp_span));
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         pv_reg <= SBF_ZERO;
      else
         pv_reg <= 16'(raw_pv + tp_shift + 32'(shift_reg));
   end

   // control output selection
   sbf_value_t out_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         out_reg <= SBF_ZERO;
      end else if (break_now) begin
         case (break_response_select_i)
            SBF_RESP_ON, SBF_RESP_LATCH: begin
               if (fallback_reg >= limits_reg.lower &&
                   fallback_reg <= limits_reg.upper)
                  out_reg <= fallback_reg;
               else
                  out_reg <= limits_reg.upper;
            end
            default: out_reg <= limits_reg.upper;
         endcase
      end else begin
         out_reg <= clamp(control_demand_i, limits_reg.lower,
                          limits_reg.upper);
      end
   end

   // alarm state
   logic alarm_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         alarm_reg <= 1'b0;
      end else begin
         case (break_response_select_i)
            SBF_RESP_ON:
               alarm_reg <= break_now;
            SBF_RESP_LATCH: begin
               if (break_now)
                  alarm_reg <= 1'b1;
               else if (ack_pulse)
                  alarm_reg <= 1'b0;
            end
            default: alarm_reg <= 1'b0;
         endcase
      end
   end

   // lamp flash timing
   logic [31:0] flash_cnt_reg;
   logic        flash_phase_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i || !alarm_reg) begin
         flash_cnt_reg   <= SBF_CNT_ZERO;
         flash_phase_reg <= 1'b1;
      end else if (flash_cnt_reg >= FLASH_CNT - SBF_CNT_ONE) begin
         flash_cnt_reg   <= SBF_CNT_ZERO;
         flash_phase_reg <= ~flash_phase_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + SBF_CNT_ONE;
      end
   end

   assign control_out_o         = out_reg;
   assign process_value_o       = pv_reg;
   assign break_active_o        = break_reg;
   assign fault_lamp_o          = alarm_reg & flash_phase_reg;
   assign alarm_relay_o         = alarm_reg;
   assign output_limits_o       = limits_reg;
   assign fallback_value_o      = fallback_reg;
   assign process_value_shift_o = shift_reg;
   assign linear_limits_o       = linear_reg;

endmodule
`default_nettype wire

// >>> sbf_break_handler_bench.sv
// testbench for the sensor-break fault handler
`timescale 1ns/1ps
`default_nettype none
module sbf_break_handler_bench;
   import sbf_pkg::*;
   logic clk, rst, lim_wr, fb_wr, sh_wr, lin_wr, det, ser, lin, cfg;
   logic open_c, press, host_en, sopen, ack, brk, lamp, rly;
   logic [1:0] lvl;
   sbf_resp_e resp;
   sbf_outmode_e mode;
   sbf_limits_s lim_d, lin_d, lim_q, lin_q;
   sbf_value_t fb_d, sh_d, mpv, mv, dem, hpv, cout, pv, fb_q, sh_q;
   sbf_host_wr_s hw;
   sbf_twopoint_s tp;
   int num_errors, checked, e_up, e_lo, e_fb, e_sh, n, seed;
   int lv[4] = '{2090, 2110, -90, -110};
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   sbf_break_handler #(.HOST_TIMEOUT_CYC(200), .FLASH_HALF_CYC(8)) DUT (
      .mclk_i(clk), .reset_i(rst), .break_response_select_i(resp),
      .output_mode_i(mode), .break_detect_en_i(det), .serial_source_i(ser),
      .linear_mode_i(lin), .config_mode_i(cfg), .access_level_i(lvl),
      .limits_wr_i(lim_wr), .limits_data_i(lim_d), .fallback_wr_i(fb_wr),
      .fallback_data_i(fb_d), .shift_wr_i(sh_wr), .shift_data_i(sh_d),
      .linear_wr_i(lin_wr), .linear_data_i(lin_d), .twopoint_i(tp),
      .sensor_open_i(sopen), .measured_pv_i(mpv), .linear_mv_i(mv),
      .control_demand_i(dem), .host_wr_i(hw), .ack_key_i(ack),
      .control_out_o(cout), .process_value_o(pv), .break_active_o(brk),
      .fault_lamp_o(lamp), .alarm_relay_o(rly), .output_limits_o(lim_q),
      .fallback_value_o(fb_q), .process_value_shift_o(sh_q),
      .linear_limits_o(lin_q));
   sbf_partner #(.PERIOD(150)) u_far (.mclk_i(clk), .host_en_i(host_en),
      .open_i(open_c), .press_i(press), .pv_i(hpv), .sensor_open_o(sopen),
      .ack_key_o(ack), .host_wr_o(hw));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   function automatic int clp(int v, int a, int b);
      return v < a ? a : (v > b ? b : v);
   endfunction
   // model of the stored limits and fallback
   function automatic void fix();
      int mn, mx;
      mn = (mode == SBF_OUT_HEAT_ONLY) ? 0 : SBF_NEG_FULL_SCALE;
      mx = (mode == SBF_OUT_COOL_ONLY) ? 0 : SBF_FULL_SCALE;
      e_up = clp(e_up, mn, mx);
      e_lo = clp(e_lo, mn, e_up);
      e_fb = clp(e_fb, e_lo, e_up);
   endfunction
   task automatic wlim(input int u, input int l);
      lim_d = '{16'(u), 16'(l)};
      lim_wr = 1;
      cyc(1);
      lim_wr = 0;
      e_up = u;
      e_lo = l;
      fix();
      chk(lim_q.upper, 16'(e_up));
      chk(lim_q.lower, 16'(e_lo));
      chk(fb_q, 16'(e_fb));
   endtask
   task automatic wfb(input int v);
      fb_d = 16'(v);
      fb_wr = 1;
      cyc(1);
      fb_wr = 0;
      fix();
      e_fb = v;
      fix();
      chk(fb_q, 16'(e_fb));
   endtask
   initial begin
      #40us;
      num_errors++;
      test_done;
   end
   initial begin
      rst = 1; resp = SBF_RESP_OFF; mode = SBF_OUT_HEAT_COOL; det = 1;
      ser = 0; lin = 0; cfg = 0; lvl = 0; lim_wr = 0; fb_wr = 0; sh_wr = 0;
      lin_wr = 0; lim_d = '0; lin_d = '0; fb_d = 0; sh_d = 0; open_c = 0;
      press = 0; host_en = 0; hpv = 0; mpv = 0; mv = 0; dem = 0;
      tp = '0;
      num_errors = 0; checked = 0; e_up = 1000; e_lo = 0; e_fb = 0; e_sh = 0;
      seed = $urandom(32'hFA0E);
      cyc(12);
      rst = 0;
      cyc(3);
      chk(lim_q.upper, 16'(e_up));
      chk(fb_q, 16'(e_fb));
      chk(lin_q.upper, SBF_LIN_MAX);
      chk(lin_q.lower, SBF_LIN_MIN);
      for (int i = 0; i < 24; i++) begin
         mode = sbf_outmode_e'(3'h1 << (i % 3));
         if (i % 2) wfb($urandom_range(2400) - 1200);
         else wlim($urandom_range(2400) - 1200, $urandom_range(2400) - 1200);
      end
      for (int i = 0; i < 3; i++) begin
         lvl = (i == 1) ? SBF_LEVEL_THREE : 2'h1;
         cfg = (i == 2);
         sh_d = 16'($urandom_range(200)) - 16'h0064;
         mpv = 16'($urandom_range(1000));
         sh_wr = 1;
         cyc(1);
         sh_wr = 0;
         if (i > 0) e_sh = sh_d;
         cyc(6);
         chk(sh_q, 16'(e_sh));
         chk(pv, 16'(int'(mpv) + e_sh));
      end
      // two-point correction: shift 10 at 0, 30 at 1000
      tp = '{16'sh0000, 16'sh03E8, 16'sh000A, 16'sh001E};
      cyc(4);
      chk(pv, 16'(int'(mpv) + 10 + (20 * int'(mpv)) / 1000 + e_sh));
      tp = '0;
      cfg = 0;
      mode = SBF_OUT_HEAT_COOL;
      wlim(700, -300);
      wfb(900);
      wfb(500);
      for (int m = 0; m < 3; m++) begin
         resp = sbf_resp_e'(3'h1 << m);
         dem = 16'($urandom_range(2000)) - 16'h03E8;
         open_c = 1;
         cyc(6);
         chk(cout, 16'(m == 0 ? e_up : e_fb));
         chk(16'(rly), 16'(m != 0));
         chk(16'(lamp), 16'(m != 0));
         press = 1;
         cyc(5);
         press = 0;
         cyc(2);
         chk(16'(rly), 16'(m != 0));
         open_c = 0;
         cyc(6);
         chk(16'(brk), 16'h0);
         chk(cout, 16'(clp(dem, e_lo, e_up)));
         chk(16'(rly), 16'(m == 2));
         press = 1;
         cyc(5);
         chk(16'(rly), 16'h0);
         open_c = 1;
         cyc(6);
         open_c = 0;
         cyc(6);
         chk(16'(rly), 16'(m == 2));
         press = 0;
         cyc(3);
         press = 1;
         cyc(5);
         press = 0;
         chk(16'(rly), 16'h0);
      end
      det = 0;
      open_c = 1;
      cyc(6);
      chk(16'(brk), 16'h0);
      open_c = 0;
      cyc(4);
      det = 1;
      cfg = 1;
      lin_d = '{16'sh07D0, 16'sh0000};
      lin_wr = 1;
      cyc(1);
      lin_wr = 0;
      cfg = 0;
      chk(lin_q.upper, 16'h07D0);
      chk(lin_q.lower, 16'h0000);
      lin = 1;
      foreach (lv[k]) begin
         mv = 16'(lv[k]);
         cyc(4);
         chk(16'(brk), 16'(lv[k] > 2100 || lv[k] < -100));
      end
      mv = 0;
      lin = 0;
      hpv = 16'h0123;
      host_en = 1;
      ser = 1;
      cyc(600);
      chk(16'(brk), 16'h0);
      chk(pv, 16'(int'(hpv) + e_sh));
      host_en = 0;
      n = 0;
      while (brk !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      chk(16'(brk), 16'h1);
      chk(16'(n > 45), 16'h1);
      chk(16'(n <= 205), 16'h1);
      host_en = 1;
      cyc(170);
      chk(16'(brk), 16'h0);
      test_done;
   end
endmodule
`default_nettype wire

// >>> sbf_partner.sv
// far-side model: sensor pin, serial host, keypad
`timescale 1ns/1ps
`default_nettype none
module sbf_partner
   import sbf_pkg::*;
#(
   parameter int PERIOD = 150
) (
   // bench commands
   input  wire logic       mclk_i,
   input  wire logic       host_en_i,
   input  wire logic       open_i,
   input  wire logic       press_i,
   input  wire sbf_value_t pv_i,
   // pins
   output logic            sensor_open_o,
   output logic            ack_key_o,
   output sbf_host_wr_s    host_wr_o
);
   int age = 0;
   initial begin
      host_wr_o = '0;
      sensor_open_o = 1'b0;
      ack_key_o = 1'b0;
   end
   // pin and key move off the clock edges
   always @(open_i) sensor_open_o <= #1.3 open_i;
   always @(press_i) ack_key_o <= #1.7 press_i;
   always @(negedge mclk_i) begin
      if (host_en_i && age >= PERIOD) begin
         host_wr_o <= '{1'b1, SBF_PV_HOLD_ADDR, pv_i};
         age <= 0;
      end else begin
         host_wr_o <= '{1'b0, ~host_wr_o.addr, ~host_wr_o.data};
         age <= age + 1;
      end
   end
endmodule
`default_nettype wire

// >>> sbf_pkg.sv
// constants, types and structs for the sensor-break fault handler
package sbf_pkg;

   typedef logic signed [15:0] sbf_value_t;

   // break response behaviours
   typedef enum logic [2:0] {
      SBF_RESP_OFF   = 3'b001,
      SBF_RESP_ON    = 3'b010,
      SBF_RESP_LATCH = 3'b100
   } sbf_resp_e;

   // control output arrangement
   typedef enum logic [2:0] {
      SBF_OUT_HEAT_COOL = 3'b001,
      SBF_OUT_HEAT_ONLY = 3'b010,
      SBF_OUT_COOL_ONLY = 3'b100
   } sbf_outmode_e;

   // lower and upper bound of a value pair
   typedef struct packed {
      sbf_value_t upper;
      sbf_value_t lower;
   } sbf_limits_s;

   // host write on the serial field bus
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      sbf_value_t  data;
   } sbf_host_wr_s;

   // two-point correction set
   typedef struct packed {
      sbf_value_t low_point;
      sbf_value_t high_point;
      sbf_value_t low_shift;
      sbf_value_t high_shift;
   } sbf_twopoint_s;

   // output percent in tenths: full scale 100.0 %
   localparam sbf_value_t SBF_FULL_SCALE     = 16'sh03E8;
   localparam sbf_value_t SBF_NEG_FULL_SCALE = -16'sh03E8;
   localparam sbf_value_t SBF_ZERO           = 16'sh0000;

   // linear input span in hundredths of a millivolt
   localparam sbf_value_t SBF_LIN_MIN = -16'sh03E8;
   localparam sbf_value_t SBF_LIN_MAX = 16'sh1F40;
   localparam int         SBF_LIN_MARGIN_DIV = 20;

   // serial process value holding register
   localparam logic [15:0] SBF_PV_HOLD_ADDR = 16'h00CB;

   // access level allowed to change the shift
   localparam logic [1:0] SBF_LEVEL_THREE = 2'h3;

   // timing
   localparam longint SBF_CLK_HZ        = 250_000_000;
   localparam longint SBF_HOST_TIMEOUT_S = 5;
   localparam longint SBF_HOST_TIMEOUT_CYC = SBF_HOST_TIMEOUT_S * SBF_CLK_HZ;
   localparam longint SBF_FLASH_HALF_MS = 500;
   localparam longint SBF_FLASH_HALF_CYC =
      SBF_FLASH_HALF_MS * SBF_CLK_HZ / 1000;

   localparam logic [31:0] SBF_CNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] SBF_CNT_ONE  = 32'h0000_0001;

endpackage

// >>> sbf_sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module sbf_sync2 (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // level in and out
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_reg;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         meta_reg <= 1'b0;
         sync_o   <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule
`default_nettype wire
